/* pin_steer_pkg.sv */
// package: register map, reset values and carrier types for the port pin steering block
// Function
// [RULE1] an enabled peripheral takes a pin from the port latch; pin stays readable
// [RULE2] writing the latch register updates latches just like writing the pin level register
// [RULE3] latch register reads latch contents; pin level register reads sampled pin levels
// [RULE4] analog select bit set disables that pin's digital input buffer
// [RULE5] alternate select steers wave A, wave B, timer gate, capcomp1, capcomp2
// [RULE6] changing alternate select bits never alters any direction register
// [RULE7] peripheral data and direction overrides follow the function to its selected pin
// [RULE8] the unselected pin keeps plain port behaviour with no override
// [RULE9] timer gate input comes from one of two pins by bit 3
// [RULE10] several enabled outputs on one pin: highest ranked peripheral wins
// [RULE11] direction bit 1 makes pin input, driver off; 0 drives latch out
// [RULE12] a pin set for analog always reads zero as digital level
// [RULE13] bits 6 and 0 set put wave A and capcomp1 on RA5, clear on RA2
// [RULE14] bit 1 puts capcomp2 on RA5 when set, RC3 when clear; unimplemented read zero
package pin_steer_pkg;

    // ==========================================================
    // register offsets (byte addresses, one word each)
    localparam logic [5:0] OFS_LEVEL_A = 6'h00;
    localparam logic [5:0] OFS_LATCH_A = 6'h04;
    localparam logic [5:0] OFS_DIR_A = 6'h08;
    localparam logic [5:0] OFS_ANALOG_A = 6'h0C;
    localparam logic [5:0] OFS_LEVEL_C = 6'h10;
    localparam logic [5:0] OFS_LATCH_C = 6'h14;
    localparam logic [5:0] OFS_DIR_C = 6'h18;
    localparam logic [5:0] OFS_ANALOG_C = 6'h1C;
    localparam logic [5:0] OFS_ALT_SEL = 6'h20;

    // ==========================================================
    // widths, fields and reset values
    localparam int PORT_W = 6;
    localparam int BIT_WAVE_A = 6;
    localparam int BIT_WAVE_B = 5;
    localparam int BIT_TGATE = 3;
    localparam int BIT_CC2 = 1;
    localparam int BIT_CC1 = 0;
    localparam int PIN_INPUT_ONLY = 3;
    localparam logic [7:0] ALT_SEL_MASK = 8'h6B;
    localparam logic [7:0] ALT_SEL_RST = 8'h00;
    localparam logic [5:0] LATCH_RST = 6'h00;
    localparam logic [5:0] DIR_RST = 6'h3F;
    localparam logic [5:0] ANALOG_RST = 6'h3F;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic en;
        logic dat;
        logic oe;
    } periph_out_t;

    typedef struct packed {
        logic [5:0] latch;
        logic [5:0] dir;
        logic [5:0] analog;
    } port_cfg_t;

    localparam periph_out_t NO_OVERRIDE = 3'h0;

endpackage

/* pin_cell.sv */
// single port pin: output mux, direction and digital input buffer
`timescale 1ns/1ps
module pin_cell (
    // port configuration
    input wire logic latch,
    input wire logic dir,
    input wire logic analog,
    // steered peripheral override
    input wire pin_steer_pkg::periph_out_t ovr,
    // pad side
    input wire logic pad_in,
    output logic pad_out,
    output logic pad_oe,
    output logic dig_in
);
    always_comb begin
        if (ovr.en) begin
            pad_out = ovr.dat; // RULE1
            pad_oe = ovr.oe; // RULE7
        end else begin
            pad_out = latch; // RULE11
            pad_oe = ~dir; // RULE11
        end
    end

    // buffer off in analog mode so mid-rail levels never toggle logic
    assign dig_in = analog ? 1'b0 : pad_in; // RULE4 RULE12
endmodule // pin_cell

/* pin_steer_top.sv */
// port latches, pin readback and alternate pin steering behind an Avalon-MM slave
//
// Our own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
module pin_steer_top (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // avalon-mm slave
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // peripheral outputs to steer
    input wire pin_steer_pkg::periph_out_t wave_out_a,
    input wire pin_steer_pkg::periph_out_t wave_out_b,
    input wire pin_steer_pkg::periph_out_t capcomp1,
    input wire pin_steer_pkg::periph_out_t capcomp2,
    // peripheral inputs from the selected pins
    output logic timer_gate_input,
    output logic capcomp1_in,
    output logic capcomp2_in,
    // pads
    input wire logic [5:0] pad_a_in,
    output logic [5:0] pad_a_out,
    output logic [5:0] pad_a_oe,
    input wire logic [5:0] pad_c_in,
    output logic [5:0] pad_c_out,
    output logic [5:0] pad_c_oe
);
    // ==========================================================
    // state
    pin_steer_pkg::port_cfg_t cfg_a_ff, cfg_c_ff;
    logic [7:0] alt_select_ff;
    logic [5:0] level_a_ff, level_c_ff;
    logic wait_ff;
    logic [31:0] rdata_ff;
    logic [5:0] pad_a_out_ff, pad_a_oe_ff, pad_c_out_ff, pad_c_oe_ff;
    logic tgate_ff, cc1_in_ff, cc2_in_ff;

    logic [5:0] dig_a, dig_c, nxt_pad_a_out, nxt_pad_a_oe, nxt_pad_c_out, nxt_pad_c_oe;
    pin_steer_pkg::periph_out_t ovr_a [6];
    pin_steer_pkg::periph_out_t ovr_c [6];
    logic wr_go, sel_a, sel_b, sel_t, sel_1, sel_2;
    logic [31:0] nxt_rdata;

    // ==========================================================
    // helpers
    function automatic pin_steer_pkg::periph_out_t steer(input pin_steer_pkg::periph_out_t p,
                                                       input logic here);
        steer = here ? p : pin_steer_pkg::NO_OVERRIDE;
    endfunction

    function automatic pin_steer_pkg::periph_out_t rank(input pin_steer_pkg::periph_out_t hi,
                                                      input pin_steer_pkg::periph_out_t lo);
        rank = hi.en ? hi : lo;
    endfunction

    assign sel_a = alt_select_ff[pin_steer_pkg::BIT_WAVE_A];
    assign sel_b = alt_select_ff[pin_steer_pkg::BIT_WAVE_B];
    assign sel_t = alt_select_ff[pin_steer_pkg::BIT_TGATE];
    assign sel_1 = alt_select_ff[pin_steer_pkg::BIT_CC1];
    assign sel_2 = alt_select_ff[pin_steer_pkg::BIT_CC2];

    // ==========================================================
    // avalon slave: one wait cycle, write lands on the edge waitrequest is seen low
    assign wr_go = avs_write && !wait_ff && avs_byteenable[0];

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wait_ff <= 1'b1;
        end else if ((avs_read || avs_write) && wait_ff) begin
            wait_ff <= 1'b0;
        end else begin
            wait_ff <= 1'b1;
        end
    end

    always_comb begin
        case (avs_address)
            pin_steer_pkg::OFS_LEVEL_A: nxt_rdata = {26'h0, level_a_ff}; // RULE3
            pin_steer_pkg::OFS_LATCH_A: nxt_rdata = {26'h0, cfg_a_ff.latch}; // RULE3
            pin_steer_pkg::OFS_DIR_A: nxt_rdata = {26'h0, cfg_a_ff.dir};
            pin_steer_pkg::OFS_ANALOG_A: nxt_rdata = {26'h0, cfg_a_ff.analog};
            pin_steer_pkg::OFS_LEVEL_C: nxt_rdata = {26'h0, level_c_ff};
            pin_steer_pkg::OFS_LATCH_C: nxt_rdata = {26'h0, cfg_c_ff.latch};
            pin_steer_pkg::OFS_DIR_C: nxt_rdata = {26'h0, cfg_c_ff.dir};
            pin_steer_pkg::OFS_ANALOG_C: nxt_rdata = {26'h0, cfg_c_ff.analog};
            pin_steer_pkg::OFS_ALT_SEL: nxt_rdata = {24'h0, alt_select_ff}; // RULE14
            default: nxt_rdata = pin_steer_pkg::UNMAPPED_READ;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rdata_ff <= 32'h0000_0000;
        end else if (avs_read && wait_ff) begin
            rdata_ff <= nxt_rdata;
        end
    end

    // ==========================================================
    // port registers
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cfg_a_ff <= {pin_steer_pkg::LATCH_RST, pin_steer_pkg::DIR_RST, pin_steer_pkg::ANALOG_RST};
            cfg_c_ff <= {pin_steer_pkg::LATCH_RST, pin_steer_pkg::DIR_RST, pin_steer_pkg::ANALOG_RST};
        end else if (wr_go) begin
            case (avs_address)
                pin_steer_pkg::OFS_LEVEL_A, pin_steer_pkg::OFS_LATCH_A:
                    cfg_a_ff.latch <= avs_writedata[5:0]; // RULE2
                pin_steer_pkg::OFS_DIR_A: begin
                    cfg_a_ff.dir <= avs_writedata[5:0];
                    // input-only pin has no driver to enable
                    cfg_a_ff.dir[pin_steer_pkg::PIN_INPUT_ONLY] <= 1'b1;
                end
                pin_steer_pkg::OFS_ANALOG_A: cfg_a_ff.analog <= avs_writedata[5:0];
                pin_steer_pkg::OFS_LEVEL_C, pin_steer_pkg::OFS_LATCH_C:
                    cfg_c_ff.latch <= avs_writedata[5:0]; // RULE2
                pin_steer_pkg::OFS_DIR_C: cfg_c_ff.dir <= avs_writedata[5:0];
                pin_steer_pkg::OFS_ANALOG_C: cfg_c_ff.analog <= avs_writedata[5:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            alt_select_ff <= pin_steer_pkg::ALT_SEL_RST;
        end else if (wr_go && avs_address == pin_steer_pkg::OFS_ALT_SEL) begin
            alt_select_ff <= avs_writedata[7:0] & pin_steer_pkg::ALT_SEL_MASK; // RULE14 RULE6
        end
    end

    // ==========================================================
    // steering
    always_comb begin
        for (int i = 0; i < pin_steer_pkg::PORT_W; i++) begin
            ovr_a[i] = pin_steer_pkg::NO_OVERRIDE; // RULE8
            ovr_c[i] = pin_steer_pkg::NO_OVERRIDE; // RULE8
        end
        ovr_a[0] = steer(wave_out_b, !sel_b); // RULE5 RULE7
        ovr_a[4] = steer(wave_out_b, sel_b); // RULE5 RULE7
        ovr_a[2] = rank(steer(wave_out_a, !sel_a), steer(capcomp1, !sel_1)); // RULE10 RULE13
        ovr_a[5] = rank(steer(wave_out_a, sel_a), // RULE10 RULE13
                        rank(steer(capcomp1, sel_1), steer(capcomp2, sel_2))); // RULE14
        ovr_c[3] = steer(capcomp2, !sel_2); // RULE14
    end

    for (genvar g = 0; g < pin_steer_pkg::PORT_W; g++) begin : g_pins
        pin_cell u_cell_a (
            .latch(cfg_a_ff.latch[g]),
            .dir(cfg_a_ff.dir[g]),
            .analog(cfg_a_ff.analog[g]),
            .ovr(ovr_a[g]),
            .pad_in(pad_a_in[g]),
            .pad_out(nxt_pad_a_out[g]),
            .pad_oe(nxt_pad_a_oe[g]),
            .dig_in(dig_a[g])
        );
        pin_cell u_cell_c (
            .latch(cfg_c_ff.latch[g]),
            .dir(cfg_c_ff.dir[g]),
            .analog(cfg_c_ff.analog[g]),
            .ovr(ovr_c[g]),
            .pad_in(pad_c_in[g]),
            .pad_out(nxt_pad_c_out[g]),
            .pad_oe(nxt_pad_c_oe[g]),
            .dig_in(dig_c[g])
        );
    end

    // ==========================================================
    // registered pads and readback
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pad_a_out_ff <= 6'h00;
            pad_a_oe_ff <= 6'h00;
            pad_c_out_ff <= 6'h00;
            pad_c_oe_ff <= 6'h00;
        end else begin
            pad_a_out_ff <= nxt_pad_a_out; // RULE1
            pad_a_oe_ff <= nxt_pad_a_oe; // RULE11
            pad_c_out_ff <= nxt_pad_c_out;
            pad_c_oe_ff <= nxt_pad_c_oe;
        end
    end

    // pin read stays live even while a peripheral owns the pin
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            level_a_ff <= 6'h00;
            level_c_ff <= 6'h00;
        end else begin
            level_a_ff <= dig_a; // RULE1 RULE3 RULE12
            level_c_ff <= dig_c;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            tgate_ff <= 1'b0;
            cc1_in_ff <= 1'b0;
            cc2_in_ff <= 1'b0;
        end else begin
            tgate_ff <= sel_t ? dig_a[3] : dig_a[4]; // RULE9
            cc1_in_ff <= sel_1 ? dig_a[5] : dig_a[2]; // RULE13
            cc2_in_ff <= sel_2 ? dig_a[5] : dig_c[3]; // RULE14
        end
    end

    assign avs_waitrequest = wait_ff;
    assign avs_readdata = rdata_ff;
    assign pad_a_out = pad_a_out_ff;
    assign pad_a_oe = pad_a_oe_ff;
    assign pad_c_out = pad_c_out_ff;
    assign pad_c_oe = pad_c_oe_ff;
    assign timer_gate_input = tgate_ff;
    assign capcomp1_in = cc1_in_ff;
    assign capcomp2_in = cc2_in_ff;

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    sequence s_req_taken;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    a_bus_answer: assert property (s_req_taken |=> s_answer)
        else $error("bus answer not one cycle after request");
    a_latch_write: assert property (wr_go && avs_address == pin_steer_pkg::OFS_LATCH_A // RULE2
        |=> cfg_a_ff.latch == $past(avs_writedata[5:0]))
        else $error("latch write lost");
    a_level_write: assert property (wr_go && avs_address == pin_steer_pkg::OFS_LEVEL_A // RULE2
        |=> cfg_a_ff.latch == $past(avs_writedata[5:0]))
        else $error("pin level write did not reach latch");
    a_latch_read: assert property (avs_read && wait_ff && avs_address == pin_steer_pkg::OFS_LATCH_C // RULE3
        |=> avs_readdata == {26'h0, $past(cfg_c_ff.latch)})
        else $error("latch readback wrong");
    a_analog_zero: assert property (cfg_a_ff.analog[1] ##1 cfg_a_ff.analog[1] // RULE4
        |-> level_a_ff[1] == 1'b0)
        else $error("analog pin read nonzero");
    a_dir_kept: assert property (wr_go && avs_address == pin_steer_pkg::OFS_ALT_SEL // RULE6
        |=> $stable(cfg_a_ff.dir) && $stable(cfg_c_ff.dir))
        else $error("direction changed by alternate select");
    a_cc2_owns: assert property (capcomp2.en && !sel_2 // RULE7
        |=> pad_c_out_ff[3] == $past(capcomp2.dat) && pad_c_oe_ff[3] == $past(capcomp2.oe))
        else $error("capcomp2 override not on RC3");
    a_unsel_pin: assert property (sel_2 // RULE8
        |=> pad_c_out_ff[3] == $past(cfg_c_ff.latch[3]) && pad_c_oe_ff[3] == !$past(cfg_c_ff.dir[3]))
        else $error("unselected pin overridden");
    a_gate_steer: assert property (sel_t |=> timer_gate_input == $past(dig_a[3])) // RULE9
        else $error("timer gate from wrong pin");
    a_priority: assert property (wave_out_a.en && capcomp1.en && !sel_a && !sel_1 // RULE10 RULE13
        |=> pad_a_out_ff[2] == $past(wave_out_a.dat))
        else $error("lower ranked peripheral won RA2");
    a_tris_in: assert property (cfg_a_ff.dir[1] |=> !pad_a_oe_ff[1]) // RULE11
        else $error("input pin driven");
    a_alt_unimpl: assert property ((alt_select_ff & ~pin_steer_pkg::ALT_SEL_MASK) == 8'h00) // RULE14
        else $error("unimplemented select bit set");
endmodule // pin_steer_top

/* pad_model.sv */
// behavioural pad: the block's drive where enabled, the outside source elsewhere
`timescale 1ns/1ps
module pad_model (
    // drive from the block
    input wire logic [5:0] drv,
    input wire logic [5:0] oe,
    // outside source on pins the block leaves undriven
    input wire logic [5:0] ext,
    // level seen back at the pads
    output logic [5:0] lvl
);
    // ==========================
    // wire resolution
    // the outside source only wins where the block lets go
    assign lvl = (drv & oe) | (ext & ~oe);
endmodule // pad_model

/* tb.sv */
// self-checking bench for the port latch and pin steering block
`timescale 1ns/1ps
module tb;
    logic clk_sys, srst, rd, wr, tg, c1i, c2i;
    logic [5:0] adr, ext_a, ext_c, pa_in, pa_out, pa_oe, pc_in, pc_out, pc_oe;
    logic [31:0] wdat, rdat, q;
    logic [3:0] ben;
    logic wreq;
    pin_steer_pkg::periph_out_t wa, wb, p1, p2;
    int failures = 0;
    int samples_checked = 0;
    int cyc = 0;

    pin_steer_top dut (.clk_sys(clk_sys), .srst(srst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wdat), .avs_byteenable(ben), .avs_readdata(rdat), .avs_waitrequest(wreq),
        .wave_out_a(wa), .wave_out_b(wb), .capcomp1(p1), .capcomp2(p2), .timer_gate_input(tg),
        .capcomp1_in(c1i), .capcomp2_in(c2i), .pad_a_in(pa_in), .pad_a_out(pa_out), .pad_a_oe(pa_oe),
        .pad_c_in(pc_in), .pad_c_out(pc_out), .pad_c_oe(pc_oe));
    pad_model pma (.drv(pa_out), .oe(pa_oe), .ext(ext_a), .lvl(pa_in));
    pad_model pmc (.drv(pc_out), .oe(pc_oe), .ext(ext_c), .lvl(pc_in));

    // ==========================
    // clock and timeout
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // whole run needs well under a thousand cycles
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            failures++;
            summarize;
        end
    end

    // ==========================
    // shared tasks
    task summarize;
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // request held until waitrequest is seen low at a rising edge
    task bus(input logic [5:0] a, input logic w, input logic [31:0] d, input logic [3:0] be);
        adr <= a;
        wdat <= d;
        ben <= be;
        rd <= ~w;
        wr <= w;
        @(posedge clk_sys);
        while (wreq !== 1'b0) @(posedge clk_sys);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task wrr(input logic [5:0] a, input logic [7:0] d);
        bus(a, 1'b1, {24'h000000, d}, 4'hF);
    endtask
    task rdc(input logic [5:0] a, input logic [7:0] e);
        bus(a, 1'b0, 32'h00000000, 4'hF);
        chk(q, {24'h000000, e});
    endtask
    task settle;
        repeat (3) @(posedge clk_sys);
    endtask

    // ==========================
    // scenarios
    task t_reset;
        chk({20'h0, pa_oe, pc_oe}, 32'h00000000);
        chk({20'h0, pa_out, pc_out}, 32'h00000000);
        rdc(pin_steer_pkg::OFS_DIR_A, 8'h3F);
        rdc(pin_steer_pkg::OFS_ANALOG_C, 8'h3F);
        rdc(pin_steer_pkg::OFS_LATCH_A, 8'h00);
        rdc(pin_steer_pkg::OFS_ALT_SEL, 8'h00);
        bus(6'h3C, 1'b1, 32'h000000FF, 4'hF);
        rdc(6'h3C, 8'h00);
    endtask
    task t_latch;
        wrr(pin_steer_pkg::OFS_LEVEL_A, 8'h15);
        rdc(pin_steer_pkg::OFS_LATCH_A, 8'h15);
        wrr(pin_steer_pkg::OFS_LEVEL_C, 8'h2A);
        rdc(pin_steer_pkg::OFS_LATCH_C, 8'h2A);
        bus(pin_steer_pkg::OFS_LATCH_C, 1'b1, 32'h0000003F, 4'h0);
        rdc(pin_steer_pkg::OFS_LATCH_C, 8'h2A);
    endtask
    task t_level;
        settle;
        rdc(pin_steer_pkg::OFS_LEVEL_A, 8'h00);
        wrr(pin_steer_pkg::OFS_ANALOG_A, 8'h00);
        wrr(pin_steer_pkg::OFS_ANALOG_C, 8'h00);
        rdc(pin_steer_pkg::OFS_ANALOG_A, 8'h00);
        settle;
        rdc(pin_steer_pkg::OFS_LEVEL_A, 8'h3F);
        rdc(pin_steer_pkg::OFS_LATCH_A, 8'h15);
        rdc(pin_steer_pkg::OFS_LEVEL_C, 8'h15);
    endtask
    task t_dir;
        wrr(pin_steer_pkg::OFS_LATCH_A, 8'h3F);
        wrr(pin_steer_pkg::OFS_DIR_A, 8'h00);
        wrr(pin_steer_pkg::OFS_DIR_C, 8'h00);
        rdc(pin_steer_pkg::OFS_DIR_A, 8'h08);
        settle;
        chk({26'h0, pa_oe}, 32'h00000037);
        chk({26'h0, pc_out & pc_oe}, 32'h0000002A);
        rdc(pin_steer_pkg::OFS_LEVEL_A, 8'h3F);
    endtask
    // drive the peripherals, select pins, compare what reaches the pads
    task sc(input logic [7:0] alt, input pin_steer_pkg::periph_out_t a, b, c1, c2, input logic [5:0] ea, ec);
        wa <= a;
        wb <= b;
        p1 <= c1;
        p2 <= c2;
        wrr(pin_steer_pkg::OFS_ALT_SEL, alt);
        settle;
        chk({26'h0, pa_out & pa_oe}, {26'h0, ea});
        chk({26'h0, pc_out & pc_oe}, {26'h0, ec});
    endtask
    task t_steer;
        sc(8'h00, 3'h0, 3'h0, 3'h5, 3'h0, 6'h33, 6'h2A);
        sc(8'h01, 3'h0, 3'h0, 3'h5, 3'h0, 6'h17, 6'h2A);
        sc(8'h41, 3'h7, 3'h0, 3'h5, 3'h0, 6'h37, 6'h2A);
        sc(8'h00, 3'h7, 3'h0, 3'h5, 3'h0, 6'h37, 6'h2A);
        sc(8'h00, 3'h0, 3'h0, 3'h0, 3'h5, 6'h37, 6'h22);
        sc(8'h02, 3'h0, 3'h0, 3'h0, 3'h5, 6'h17, 6'h2A);
        sc(8'h20, 3'h0, 3'h5, 3'h0, 3'h0, 6'h27, 6'h2A);
        sc(8'h00, 3'h0, 3'h5, 3'h0, 3'h0, 6'h36, 6'h2A);
        wrr(pin_steer_pkg::OFS_ALT_SEL, 8'hFF);
        rdc(pin_steer_pkg::OFS_ALT_SEL, 8'h6B);
        rdc(pin_steer_pkg::OFS_DIR_A, 8'h08);
        rdc(pin_steer_pkg::OFS_DIR_C, 8'h00);
    endtask
    task ic(input logic [7:0] alt, input logic [2:0] e);
        wrr(pin_steer_pkg::OFS_ALT_SEL, alt);
        settle;
        chk({29'h0, tg, c1i, c2i}, {29'h0, e});
    endtask
    // pads released: RA3 and RA5 high, RA2, RA4 and RC3 low
    task t_inputs;
        wa <= pin_steer_pkg::NO_OVERRIDE;
        wb <= pin_steer_pkg::NO_OVERRIDE;
        p1 <= pin_steer_pkg::NO_OVERRIDE;
        p2 <= pin_steer_pkg::NO_OVERRIDE;
        ext_a <= 6'h28;
        ext_c <= 6'h00;
        wrr(pin_steer_pkg::OFS_DIR_A, 8'h3F);
        wrr(pin_steer_pkg::OFS_DIR_C, 8'h3F);
        ic(8'h0B, 3'h7);
        ic(8'h08, 3'h4);
        ic(8'h01, 3'h2);
        ic(8'h02, 3'h1);
        ic(8'h00, 3'h0);
    endtask

    // ==========================
    // main sequence
    initial begin
        srst = 1'b1;
        rd = 1'b0;
        wr = 1'b0;
        adr = 6'h00;
        wdat = 32'h00000000;
        ben = 4'h0;
        wa = pin_steer_pkg::NO_OVERRIDE;
        wb = pin_steer_pkg::NO_OVERRIDE;
        p1 = pin_steer_pkg::NO_OVERRIDE;
        p2 = pin_steer_pkg::NO_OVERRIDE;
        ext_a = 6'h3F;
        ext_c = 6'h15;
        repeat (8) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        t_reset;
        t_latch;
        t_level;
        t_dir;
        t_steer;
        t_inputs;
        summarize;
    end
endmodule // tb
